/* rtl/charger_pkg.sv */
// Constants, register map and state type of the charger I2C register slave
package charger_pkg;

   // Bus address of the slave and the prefix of a high-speed master code
   localparam logic [6:0] DEV_ADDR           = 7'h35;
   localparam logic [4:0] MASTER_CODE_PREFIX = 5'h01;

   // Register pointers
   localparam logic [7:0] REG_MASK       = 8'h01;
   localparam logic [7:0] REG_SUMMARY    = 8'h02;
   localparam logic [7:0] REG_THERMAL    = 8'h03;
   localparam logic [7:0] REG_CHARGE     = 8'h04;
   localparam logic [7:0] REG_CTRL_FIRST = 8'h05;
   localparam logic [7:0] REG_CTRL_LAST  = 8'h0A;
   localparam logic [7:0] REG_EVENT      = 8'h0F;

   // Values after a register reset
   localparam int                         CTRL_COUNT  = 6;
   localparam logic [7:0]                 FLAGS_RESET = 8'h01;
   localparam logic [7:0]                 MASK_RESET  = 8'h00;
   localparam logic [CTRL_COUNT-1:0][7:0] CTRL_RESET  = {CTRL_COUNT{8'h00}};

   // Event flag positions
   localparam int EV_LIMIT_BIT = 7;
   localparam int EV_EOC_BIT   = 6;
   localparam int EV_OVP_BIT   = 5;
   localparam int EV_UVP_BIT   = 4;
   localparam int EV_CHG_BIT   = 3;
   localparam int EV_BAT_BIT   = 2;
   localparam int EV_THM_BIT   = 1;
   localparam int EV_RESET_BIT = 0;

   // Bit counts of one byte on the bus
   localparam logic [3:0] BYTE_BITS   = 4'h8;
   localparam logic [2:0] LAST_TX_BIT = 3'h7;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_PTR,
      ST_PTR_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RDATA_ACK
   } i2c_state_t;

endpackage

/* rtl/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync #(
   parameter bit RESET_VAL = 1'b1
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic pin,
   output logic      level
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_reg;

   // Stage one feeds stage two only
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_reg    <= RESET_VAL;
         s2_reg    <= RESET_VAL;
         s3_reg    <= RESET_VAL;
         level_reg <= RESET_VAL;
      end else if (ce) begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         // Single-cycle glitches never reach the level
         if (s2_reg == s3_reg) begin
            level_reg <= s3_reg;
         end
      end
   end

   assign level = level_reg;
endmodule

/* rtl/event_bit.sv */
// One sticky event flag set by a status change and cleared by a read
`timescale 1ns/100ps
module event_bit #(
   parameter bit RISE_ONLY = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic status,
   input  wire logic clr,
   output logic      flag,
   output logic      set
);
   logic prev_reg;
   logic flag_reg;

   assign set = RISE_ONLY ? (status & ~prev_reg) : (status ^ prev_reg);

   always_ff @(posedge clk) begin
      if (rst) begin
         prev_reg <= status;
         flag_reg <= 1'b0;
      end else if (ce) begin
         prev_reg <= status;
         // A change in the clearing cycle survives the read
         if (set) begin
            flag_reg <= 1'b1;
         end else if (clr) begin
            flag_reg <= 1'b0;
         end
      end
   end

   assign flag = flag_reg;
endmodule

/* rtl/charger_i2c_regs.sv */
// I2C register slave of the charger: protocol engine, register map, event flags
`timescale 1ns/100ps
// What this block does
// - Master ack fetches next sequential register
// - Ack write address after START
// - Ack the register pointer byte
// - Ack read address after repeated START
// - Shift out pointed register, eight bits
// - STOP resets filters, Sr keeps them
// - Supply loss or power-good rise resets map
// - Input limit status change sets bit 7
// - End-of-charge entry sets bit 6
// - Overvoltage change sets bit 5
// - Undervoltage change sets bit 4
// - Charger, battery, thermistor changes set 3-1
// - Reading event register clears its flags
// - Bit 0 flags register reset, value 0x01
// - Mask bits 7-1, reset 0x00
// - Answer only address 0110101
// - Never ack general call
// - Never drive the clock line
// - Write data commits at ack rising edge
module charger_i2c_regs
   import charger_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       ce,
   input  wire logic       rst,
   input  wire logic       scl_in,
   output logic            scl_out,
   output logic            scl_oe_n,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   input  wire logic       standby_supply,
   input  wire logic       safeout_power_good,
   input  wire logic       input_limit_status,
   input  wire logic       end_of_charge,
   input  wire logic       input_overvoltage_status,
   input  wire logic       input_undervoltage_status,
   input  wire logic       charger_state_status,
   input  wire logic       battery_state_status,
   input  wire logic       thermistor_state_status,
   input  wire logic [7:0] summary_status_in,
   input  wire logic [7:0] thermal_condition_in,
   input  wire logic [7:0] charge_condition_in,
   output logic [7:0]      charge_control_one,
   output logic [7:0]      fast_charge_current_timer,
   output logic [7:0]      input_current_limit,
   output logic [7:0]      end_of_charge_setting,
   output logic [7:0]      thermal_regulation_setting,
   output logic [7:0]      setting_write_protect,
   output logic            hs_filter_mode,
   output logic            event_int_n
);
   logic       scl_f;
   logic       sda_f;
   logic       stby_f;
   logic       pg_f;
   logic       scl_q;
   logic       sda_q;
   logic       pg_q;
   logic       reg_reset;
   logic       start_det;
   logic       stop_det;
   logic       scl_rise;
   logic       scl_fall;
   i2c_state_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic [7:0] ptr_reg;
   logic       rw_reg;
   logic       ack_reg;
   logic       byte_done;
   logic       addr_match;
   logic       mc_seen;
   logic       tx_load;
   logic       wr_commit;
   logic       flags_clr;
   logic [7:0] rd_data;
   logic [7:0] flags;
   logic [7:1] ev_status;
   logic [7:1] ev_flag;
   logic [7:1] ev_set;
   logic       reset_flag_reg;
   logic [7:1] mask_reg;
   logic [7:0] ctrl_reg [0:CTRL_COUNT-1];
   logic [7:0] ctrl_off;
   logic       ctrl_hit;
   logic       hs_mode_reg;
   logic       event_int_n_reg;
   logic       sda_oe_n_reg;
   logic       scl_oe_n_reg;
   logic       pin_low_reg;

   pin_sync #(.RESET_VAL(1'b1)) u_scl_sync (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .pin   (scl_in),
      .level (scl_f)
   );
   pin_sync #(.RESET_VAL(1'b1)) u_sda_sync (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .pin   (sda_in),
      .level (sda_f)
   );
   pin_sync #(.RESET_VAL(1'b1)) u_stby_sync (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .pin   (standby_supply),
      .level (stby_f)
   );
   pin_sync #(.RESET_VAL(1'b0)) u_pg_sync (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .pin   (safeout_power_good),
      .level (pg_f)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         pg_q  <= 1'b0;
      end else if (ce) begin
         scl_q <= scl_f;
         sda_q <= sda_f;
         pg_q  <= pg_f;
      end
   end

   assign reg_reset = rst | ~stby_f | (ce & pg_f & ~pg_q);
   assign start_det = scl_f & scl_q & sda_q & ~sda_f;
   assign stop_det  = scl_f & scl_q & ~sda_q & sda_f;
   assign scl_rise  = scl_f & ~scl_q;
   assign scl_fall  = ~scl_f & scl_q;

   assign byte_done  = scl_fall && bit_cnt_reg == BYTE_BITS &&
                       (state_reg == ST_ADDR || state_reg == ST_PTR || state_reg == ST_WDATA);
   // General call and every other address fail this compare
   assign addr_match = shift_reg[7:1] == DEV_ADDR;
   assign mc_seen    = byte_done && state_reg == ST_ADDR && shift_reg[7:3] == MASTER_CODE_PREFIX;
   assign tx_load    = ce && scl_fall &&
                       ((state_reg == ST_ADDR_ACK && rw_reg) || (state_reg == ST_RDATA_ACK && ack_reg));
   assign wr_commit  = ce && scl_rise && state_reg == ST_WDATA_ACK;
   assign flags_clr  = tx_load && ptr_reg == REG_EVENT;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg    <= ST_IDLE;
         bit_cnt_reg  <= 4'h0;
         shift_reg    <= 8'h00;
         tx_reg       <= 8'h00;
         ptr_reg      <= 8'h00;
         rw_reg       <= 1'b0;
         ack_reg      <= 1'b0;
         sda_oe_n_reg <= 1'b1;
      end else if (ce) begin
         if (stop_det) begin
            state_reg    <= ST_IDLE;
            sda_oe_n_reg <= 1'b1;
         end else if (start_det) begin
            state_reg    <= ST_ADDR;
            bit_cnt_reg  <= 4'h0;
            sda_oe_n_reg <= 1'b1;
         end else begin
            case (state_reg)
               ST_ADDR, ST_PTR, ST_WDATA: begin
                  if (scl_rise && bit_cnt_reg != BYTE_BITS) begin
                     shift_reg   <= {shift_reg[6:0], sda_f};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (byte_done) begin
                     bit_cnt_reg <= 4'h0;
                     if (state_reg == ST_PTR) begin
                        ptr_reg      <= shift_reg;
                        sda_oe_n_reg <= 1'b0;
                        state_reg    <= ST_PTR_ACK;
                     end else if (state_reg == ST_WDATA) begin
                        sda_oe_n_reg <= 1'b0;
                        state_reg    <= ST_WDATA_ACK;
                     end else if (addr_match) begin
                        rw_reg       <= shift_reg[0];
                        sda_oe_n_reg <= 1'b0;
                        state_reg    <= ST_ADDR_ACK;
                     end else begin
                        // Foreign address: stay off the bus until the next START
                        state_reg <= ST_IDLE;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  if (scl_fall) begin
                     bit_cnt_reg <= 4'h0;
                     if (rw_reg) begin
                        tx_reg       <= rd_data;
                        sda_oe_n_reg <= rd_data[7];
                        ptr_reg      <= ptr_reg + 8'h01;
                        state_reg    <= ST_RDATA;
                     end else begin
                        sda_oe_n_reg <= 1'b1;
                        state_reg    <= ST_PTR;
                     end
                  end
               end
               ST_PTR_ACK: begin
                  if (scl_fall) begin
                     sda_oe_n_reg <= 1'b1;
                     state_reg    <= ST_WDATA;
                  end
               end
               ST_WDATA_ACK: begin
                  if (scl_rise) begin
                     ptr_reg <= ptr_reg + 8'h01;
                  end
                  if (scl_fall) begin
                     sda_oe_n_reg <= 1'b1;
                     state_reg    <= ST_WDATA;
                  end
               end
               ST_RDATA: begin
                  if (scl_fall) begin
                     if (bit_cnt_reg[2:0] == LAST_TX_BIT) begin
                        sda_oe_n_reg <= 1'b1;
                        state_reg    <= ST_RDATA_ACK;
                     end else begin
                        tx_reg       <= {tx_reg[6:0], 1'b0};
                        sda_oe_n_reg <= tx_reg[6];
                        bit_cnt_reg  <= bit_cnt_reg + 4'h1;
                     end
                  end
               end
               ST_RDATA_ACK: begin
                  if (scl_rise) begin
                     ack_reg <= ~sda_f;
                  end else if (scl_fall) begin
                     bit_cnt_reg <= 4'h0;
                     if (ack_reg) begin
                        tx_reg       <= rd_data;
                        sda_oe_n_reg <= rd_data[7];
                        ptr_reg      <= ptr_reg + 8'h01;
                        state_reg    <= ST_RDATA;
                     end else begin
                        state_reg <= ST_IDLE;
                     end
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // High-speed filters only after a master code; a repeated START leaves them alone
   always_ff @(posedge clk) begin
      if (rst) begin
         hs_mode_reg <= 1'b0;
      end else if (ce) begin
         if (stop_det) begin
            hs_mode_reg <= 1'b0;
         end else if (mc_seen) begin
            hs_mode_reg <= 1'b1;
         end
      end
   end

   assign ev_status = {input_limit_status, end_of_charge, input_overvoltage_status,
                       input_undervoltage_status, charger_state_status,
                       battery_state_status, thermistor_state_status};

   generate
      for (genvar i = 1; i <= 7; i++) begin : g_event
         event_bit #(.RISE_ONLY(i == EV_EOC_BIT)) u_event (
            .clk    (clk),
            .rst    (reg_reset),
            .ce     (ce),
            .status (ev_status[i]),
            .clr    (flags_clr),
            .flag   (ev_flag[i]),
            .set    (ev_set[i])
         );
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (reg_reset) begin
         reset_flag_reg <= FLAGS_RESET[EV_RESET_BIT];
      end else if (ce && flags_clr) begin
         reset_flag_reg <= 1'b0;
      end
   end

   assign flags = {ev_flag, reset_flag_reg};

   always_ff @(posedge clk) begin
      if (reg_reset) begin
         mask_reg <= MASK_RESET[7:1];
      end else if (wr_commit && ptr_reg == REG_MASK) begin
         mask_reg <= shift_reg[7:1];
      end
   end

   assign ctrl_off = ptr_reg - REG_CTRL_FIRST;
   assign ctrl_hit = ptr_reg >= REG_CTRL_FIRST && ptr_reg <= REG_CTRL_LAST;

   always_ff @(posedge clk) begin
      if (reg_reset) begin
         for (int i = 0; i < CTRL_COUNT; i++) begin
            ctrl_reg[i] <= CTRL_RESET[i];
         end
      end else if (wr_commit && ctrl_hit) begin
         ctrl_reg[ctrl_off[2:0]] <= shift_reg;
      end
   end

   always_comb begin
      rd_data = 8'h00;
      case (ptr_reg)
         REG_MASK:    rd_data = {mask_reg, 1'b0};
         REG_SUMMARY: rd_data = summary_status_in;
         REG_THERMAL: rd_data = thermal_condition_in;
         REG_CHARGE:  rd_data = charge_condition_in;
         REG_EVENT:   rd_data = flags;
         default: begin
            if (ctrl_hit) begin
               rd_data = ctrl_reg[ctrl_off[2:0]];
            end
         end
      endcase
   end

   // Register-reset flag has no mask bit, so it always reaches the pin
   always_ff @(posedge clk) begin
      if (rst) begin
         event_int_n_reg <= 1'b1;
      end else if (ce) begin
         event_int_n_reg <= ~|(flags & ~{mask_reg, 1'b0});
      end
   end

   // Clock line is only ever released
   always_ff @(posedge clk) begin
      scl_oe_n_reg <= 1'b1;
      pin_low_reg  <= 1'b0;
   end

   assign scl_out                    = pin_low_reg;
   assign scl_oe_n                   = scl_oe_n_reg;
   assign sda_out                    = pin_low_reg;
   assign sda_oe_n                   = sda_oe_n_reg;
   assign hs_filter_mode             = hs_mode_reg;
   assign event_int_n                = event_int_n_reg;
   assign charge_control_one         = ctrl_reg[0];
   assign fast_charge_current_timer  = ctrl_reg[1];
   assign input_current_limit        = ctrl_reg[2];
   assign end_of_charge_setting      = ctrl_reg[3];
   assign thermal_regulation_setting = ctrl_reg[4];
   assign setting_write_protect      = ctrl_reg[5];

   sequence s_addr_hit;
      ce && byte_done && state_reg == ST_ADDR && addr_match;
   endsequence
   sequence s_master_ack;
      ce && scl_fall && state_reg == ST_RDATA_ACK;
   endsequence

   a_addr_ack: assert property (@(posedge clk) disable iff (rst)
      s_addr_hit |=> !sda_oe_n_reg && state_reg == ST_ADDR_ACK) else $error("address not acknowledged");
   a_general_call: assert property (@(posedge clk) disable iff (rst)
      ce && byte_done && state_reg == ST_ADDR && shift_reg == 8'h00 |=> sda_oe_n_reg) else $error("general call acked");
   a_ptr_ack: assert property (@(posedge clk) disable iff (rst)
      ce && byte_done && state_reg == ST_PTR |=> !sda_oe_n_reg && ptr_reg == $past(shift_reg))
      else $error("pointer not acknowledged");
   a_read_start: assert property (@(posedge clk) disable iff (rst)
      ce && tx_load |=> sda_oe_n_reg == $past(rd_data[7]) && ptr_reg == $past(ptr_reg) + 8'h01)
      else $error("read byte not started from pointer");
   a_more_data: assert property (@(posedge clk) disable iff (rst)
      s_master_ack ##0 ack_reg |=> state_reg == ST_RDATA) else $error("master ack did not fetch next byte");
   a_nack_end: assert property (@(posedge clk) disable iff (rst)
      s_master_ack ##0 !ack_reg |=> state_reg == ST_IDLE ##1 sda_oe_n_reg) else $error("read continued after nack");
   a_stop_filter: assert property (@(posedge clk) disable iff (rst)
      ce && stop_det |=> !hs_mode_reg) else $error("filters not reset by stop");
   a_sr_filter: assert property (@(posedge clk) disable iff (rst)
      ce && start_det |=> $stable(hs_mode_reg)) else $error("repeated start changed filters");
   a_map_reset: assert property (@(posedge clk) disable iff (rst)
      reg_reset |=> flags == FLAGS_RESET && mask_reg == MASK_RESET[7:1]) else $error("map not reset");
   a_ovp_event: assert property (@(posedge clk) disable iff (rst)
      ce && $past(ce) && $changed(input_overvoltage_status) && !reg_reset |=> flags[EV_OVP_BIT])
      else $error("overvoltage change lost");
   a_eoc_event: assert property (@(posedge clk) disable iff (rst)
      ce && $past(ce) && $rose(end_of_charge) && !reg_reset |=> flags[EV_EOC_BIT]) else $error("end of charge lost");
   a_read_clear: assert property (@(posedge clk) disable iff (rst)
      flags_clr && !(|ev_set) && !reg_reset |=> flags == 8'h00) else $error("event read did not clear");
   a_mask_write: assert property (@(posedge clk) disable iff (rst)
      wr_commit && ptr_reg == REG_MASK && !reg_reset |=> mask_reg == $past(shift_reg[7:1]))
      else $error("mask write lost");
   a_irq_level: assert property (@(posedge clk) disable iff (rst)
      ce && |(flags & ~{mask_reg, 1'b0}) |=> !event_int_n_reg) else $error("interrupt not raised");
   a_no_stretch: assert property (@(posedge clk) disable iff (rst)
      ##1 scl_oe_n) else $error("clock line driven");
endmodule

/* verif/i2c_master_model.sv */
// Behavioural I2C bus master driving the slave's clock and data lines
`timescale 1ns/100ps
module i2c_master_model (
   output logic      scl,
   output logic      sda,
   input  wire logic sda_line
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Data moves mid-low so it never changes while the clock is high
   task automatic bit_io(input logic b, output logic r);
      #40 sda = b;
      #40 scl = 1'b1;
      #40 r = sda_line;
      #40 scl = 1'b0;
   endtask
   // Also serves as repeated start; clock stands high between frames
   task automatic start();
      #40 sda = 1'b1;
      #40 scl = 1'b1;
      #80 sda = 1'b0;
      #80 scl = 1'b0;
   endtask
   task automatic stop();
      #40 sda = 1'b0;
      #40 scl = 1'b1;
      #80 sda = 1'b1;
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // Ack asks for another byte, nack ends the read
   task automatic recv(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(~more, r);
   endtask
endmodule

/* verif/charger_i2c_register_interrupts_bench.sv */
// Self-checking bench of the charger I2C register slave
`timescale 1ns/100ps
module charger_i2c_register_interrupts_bench;
   import charger_pkg::*;
   typedef struct {logic [7:0] p; logic [7:0] w; logic [7:0] e;} row_t;
   logic       clk, rst, scl_m, sda_m, scl_out, scl_oe_n, sda_out, sda_oe_n;
   logic       stby, pgood, hs, int_n, a, ce;
   logic       scl_low = 1'b0;
   logic [7:1] ev;
   logic [7:0] ctrl [0:5];
   logic [7:0] q [0:3];
   logic [7:0] bad [3] = '{8'h6C, 8'h00, 8'h5A};
   int         failures, checks, cycles;
   wire        scl_w = scl_m & (scl_oe_n | scl_out);
   wire        sda_w = sda_m & (sda_oe_n | sda_out);
   // Mask row last so the supply-loss test proves the mask resets
   row_t rows [11] = '{'{8'h05,8'h5A,8'h5A}, '{8'h06,8'hC3,8'hC3}, '{8'h07,8'h81,8'h81}, '{8'h08,8'h7E,8'h7E},
      '{8'h09,8'h24,8'h24}, '{8'h0A,8'hFF,8'hFF}, '{8'h02,8'h00,8'hA5}, '{8'h03,8'hFF,8'h3C},
      '{8'h04,8'h11,8'h96}, '{8'h0C,8'h77,8'h00}, '{8'h01,8'hFF,8'hFE}};

   charger_i2c_regs dut_u (
      .clk(clk), .ce(ce), .rst(rst), .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .standby_supply(stby),
      .safeout_power_good(pgood), .input_limit_status(ev[7]), .end_of_charge(ev[6]),
      .input_overvoltage_status(ev[5]), .input_undervoltage_status(ev[4]), .charger_state_status(ev[3]),
      .battery_state_status(ev[2]), .thermistor_state_status(ev[1]), .summary_status_in(8'hA5),
      .thermal_condition_in(8'h3C), .charge_condition_in(8'h96), .charge_control_one(ctrl[0]),
      .fast_charge_current_timer(ctrl[1]), .input_current_limit(ctrl[2]), .end_of_charge_setting(ctrl[3]),
      .thermal_regulation_setting(ctrl[4]), .setting_write_protect(ctrl[5]), .hs_filter_mode(hs),
      .event_int_n(int_n));
   i2c_master_model m_u (.scl(scl_m), .sda(sda_m), .sda_line(sda_w));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic done(input string name);
      $display("test %s finished", name);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] ptr, input int n);
      m_u.start();
      m_u.send(8'h6A, a);
      check("write address ack", {7'h00, a}, 8'h01);
      m_u.send(ptr, a);
      check("pointer ack", {7'h00, a}, 8'h01);
      for (int i = 0; i < n; i++) m_u.send(q[i], a);
      m_u.stop();
   endtask
   task automatic rd(input logic [7:0] ptr, input int n);
      m_u.start();
      m_u.send(8'h6A, a);
      m_u.send(ptr, a);
      m_u.start();
      m_u.send(8'h6B, a);
      check("read address ack", {7'h00, a}, 8'h01);
      for (int i = 0; i < n; i++) m_u.recv(i < n - 1, q[i]);
      m_u.stop();
   endtask

   // Hang guard, and a watch that the slave never drives the clock line
   always @(posedge clk) begin
      cycles++;
      if (cycles > 2 && scl_oe_n !== 1'b1) scl_low <= 1'b1;
      if (cycles == 60000) begin
         failures++;
         end_of_test();
      end
   end

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      stby = 1'b1;
      pgood = 1'b0;
      ev = '0;
      cyc(2);
      rst = 1'b0;
      cyc(10);
      foreach (rows[i]) begin
         q[0] = rows[i].w;
         wr(rows[i].p, 1);
         rd(rows[i].p, 1);
         check("readback", q[0], rows[i].e);
      end
      for (int i = 0; i < 6; i++) check("control port", ctrl[i], rows[i].e);
      done("map");
      q = '{8'h11, 8'h22, 8'h33, 8'h44};
      wr(8'h05, 4);
      rd(8'h05, 4);
      for (int i = 0; i < 4; i++) check("sequential", q[i], 8'(8'h11 * (i + 1)));
      done("sequential");
      stby = 1'b0;
      cyc(8);
      stby = 1'b1;
      cyc(8);
      check("control after supply loss", ctrl[0], 8'h00);
      check("interrupt after reset", {7'h00, int_n}, 8'h00);
      rd(REG_MASK, 1);
      check("mask after supply loss", q[0], MASK_RESET);
      rd(REG_EVENT, 1);
      check("flags after reset", q[0], FLAGS_RESET);
      rd(REG_EVENT, 1);
      check("flags cleared", q[0], 8'h00);
      check("interrupt released", {7'h00, int_n}, 8'h01);
      cyc(1);
      pgood = 1'b1;
      cyc(8);
      rd(REG_EVENT, 1);
      check("flags after power good", q[0], FLAGS_RESET);
      done("register reset");
      for (int k = 7; k > 0; k--) begin
         cyc(1);
         ev[k] = ~ev[k];
         cyc(3);
         check("interrupt on event", {7'h00, int_n}, 8'h00);
         rd(REG_EVENT, 1);
         check("event flag", q[0], 8'h01 << k);
      end
      q[0] = 8'h80;
      wr(REG_MASK, 1);
      cyc(1);
      ev[7] = ~ev[7];
      ev[6] = 1'b0;
      cyc(3);
      check("masked interrupt", {7'h00, int_n}, 8'h01);
      rd(REG_EVENT, 1);
      check("masked flag kept", q[0], 8'h80);
      // Frozen block must hold the change and flag it on resume
      ce = 1'b0;
      ev[1] = ~ev[1];
      cyc(4);
      check("frozen interrupt", {7'h00, int_n}, 8'h01);
      ce = 1'b1;
      cyc(3);
      check("interrupt after resume", {7'h00, int_n}, 8'h00);
      rd(REG_EVENT, 1);
      check("flag after resume", q[0], 8'h02);
      done("events");
      cyc(1);
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      cyc(10);
      check("control after rst", ctrl[5], CTRL_RESET[5]);
      rd(REG_MASK, 1);
      check("mask after rst", q[0], MASK_RESET);
      foreach (bad[i]) begin
         m_u.start();
         m_u.send(bad[i], a);
         m_u.stop();
         check("foreign address refused", {7'h00, a}, 8'h00);
      end
      m_u.start();
      m_u.send(8'h08, a);
      check("master code refused", {7'h00, a}, 8'h00);
      m_u.start();
      check("fast filter kept on restart", {7'h00, hs}, 8'h01);
      m_u.send(8'h6A, a);
      m_u.stop();
      cyc(8);
      check("fast filter left on stop", {7'h00, hs}, 8'h00);
      check("clock never held", {7'h00, scl_low}, 8'h00);
      check("clock drive value", {7'h00, scl_out}, 8'h00);
      done("bus");
      end_of_test();
   end
endmodule
